// ### hap_defines.svh
`ifndef HAP_DEFINES_SVH
`define HAP_DEFINES_SVH

// Host word address width and local bus width
`define HAP_ADDR_W 27
`define HAP_LAD_W 32
// Zero pad that lifts a word address onto the local bus
`define HAP_LAD_PAD 5'h0
// I/O register window: top address bits equal to the tag
`define HAP_IO_HI 26
`define HAP_IO_LO 6
`define HAP_IO_TAG 21'h1FFFFF
// I/O register index field inside the window
`define HAP_IO_IDX_HI 5
`define HAP_IO_IDX_LO 0
// Block mode walks one word per prefetch
`define HAP_ADDR_STEP 27'h0000001
// Width of the bundle of host pins passed through the synchroniser
`define HAP_SYNC_W 30

`endif

// ### hap_pkg.sv
`include "hap_defines.svh"

package hap_pkg;

   // Quarter cycle of the internal machine cycle, one clock each
   typedef enum logic [3:0] {
      Q1 = 4'h1,
      Q2 = 4'h2,
      Q3 = 4'h4,
      Q4 = 4'h8
   } hap_quarter_t;

   // Kind of local memory cycle running in the current machine cycle
   typedef enum logic [3:0] {
      CY_IDLE = 4'h1,
      CY_READ = 4'h2,
      CY_WRITE = 4'h4,
      CY_PREF = 4'h8
   } hap_cycle_t;

   // Host access mode
   typedef enum logic [1:0] {
      MODE_RANDOM = 2'h0,
      MODE_BLOCK = 2'h1,
      MODE_RMW = 2'h2
   } hap_mode_t;

   // Strobes towards the local bus and the external latches
   typedef struct packed {
      logic dataLatchStrobe;
      logic dirOutEn_n;
      logic dirInEn_n;
      logic latchOutEn_n;
      logic addrLatch_n;
      logic transferOutEn_n;
      logic colStrobe_n;
      logic writeEnable_n;
      logic ladOutEn_n;
      logic ioReadStrobe;
      logic ioWriteStrobe;
   } hap_pins_t;

   // Whole state of the port
   typedef struct packed {
      hap_quarter_t quarter;
      hap_cycle_t cycle;
      logic cycIo;
      logic [`HAP_ADDR_W-1:0] cycAddr;
      logic [`HAP_ADDR_W-1:0] hostAddr;
      logic [`HAP_ADDR_W-1:0] lastAddr;
      logic [`HAP_ADDR_W-1:0] prefAddr;
      logic prefValid;
      logic prefPending;
      logic served;
      logic servedWrite;
      logic reqPrev;
      logic csPrev_n;
      logic ready;
      hap_pins_t pins;
      logic [`HAP_LAD_W-1:0] ladOut;
      logic [`HAP_LAD_W-1:0] ioWriteData;
   } hap_state_t;

endpackage

// ### hap_sync.sv
// Two-stage synchroniser for a bundle of asynchronous host pins
module hap_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Raw and synchronised levels
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   // First stage, read only by the second stage
   logic [W-1:0] meta;

   // Both stages load the idle level under reset
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta <= INIT;
         dout <= INIT;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule

// ### hap_port.sv
`include "hap_defines.svh"

// Operation
// [R1] Sample host request at Q4, cycle at Q1
// [R2] Late request waits for the next Q4
// [R3] Host drops select on ready, reasserts before Q4
// [R4] Read ready at Q2, latch strobe at Q4
// [R5] Block mode prefetches next word on release
// [R6] Block mode prefetches on strobe or select release
// [R7] Prefetch address hit gives immediate ready
// [R8] Read-modify-write reads location after write release
// [R9] I/O read suppresses transfer and column strobes
// [R10] I/O read enables outbound buffer direction
// [R11] I/O registers reachable in every mode
// [R12] First write gets ready immediately
// [R13] Second write waits for memory write completion
// [R14] Inbound buffer direction held through write cycle
// [R15] Write cycle ends at Q4, strobes return high
// [R16] Host latches new write data after Q4
// [R17] Ready low until data or buffer available
module hap_port
   import hap_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Host pins, asynchronous to the clock
   input wire logic host_select_n,
   input wire logic host_read_strobe_n,
   input wire logic host_write_strobe_n,
   input wire logic [`HAP_ADDR_W-1:0] hostAddr,
   // Host handshake and external latch control
   output logic host_ready,
   output logic host_data_latch_strobe,
   output logic host_latch_out_en_n,
   output logic buffer_dir_out_en_n,
   output logic buffer_dir_in_en_n,
   // Local memory strobes
   output logic addr_latch_strobe_n,
   output logic transfer_out_en_n,
   output logic colStrobe_n,
   output logic writeEnable_n,
   // Local address/data bus, split into three signals
   input wire logic [`HAP_LAD_W-1:0] local_addr_data_bus_in,
   output logic [`HAP_LAD_W-1:0] local_addr_data_bus_out,
   output logic local_addr_data_bus_oe_n,
   // Access mode from the processor core
   input wire hap_mode_t accessMode,
   // Internal I/O register port
   input wire logic [`HAP_LAD_W-1:0] ioReadData,
   output logic ioReadStrobe,
   output logic ioWriteStrobe,
   output logic [`HAP_IO_IDX_HI:0] ioIndex,
   output logic [`HAP_LAD_W-1:0] ioWriteData
);

   // Registered and next state
   hap_state_t s;
   hap_state_t next_s;
   // Synchronised host pins
   logic [`HAP_SYNC_W-1:0] syncIn;
   logic [`HAP_SYNC_W-1:0] syncOut;
   logic csS_n;
   logic rdS_n;
   logic wrS_n;
   logic [`HAP_ADDR_W-1:0] addrS;
   // Decoded host request
   logic reqActive;
   logic reqWrite;
   logic csFall;
   logic [`HAP_ADDR_W-1:0] curAddr;

   // True when a word address falls in the I/O register window
   function automatic logic isIo(input logic [`HAP_ADDR_W-1:0] a);
      isIo = (a[`HAP_IO_HI:`HAP_IO_LO] == `HAP_IO_TAG);
   endfunction

   // Pin levels for one quarter of a given cycle kind
   function automatic hap_pins_t phasePins(input hap_cycle_t c,
                                           input logic io,
                                           input hap_quarter_t q);
      logic act;
      logic rdLike;
      logic mid;
      act = (c != CY_IDLE);
      rdLike = (c == CY_READ) || (c == CY_PREF);
      mid = (q == Q2) || (q == Q3);
      // Address latch and host latch enable rise at Q4 - see R15
      phasePins.addrLatch_n = !(act && q != Q4);
      phasePins.latchOutEn_n = !(c == CY_WRITE && q != Q4);
      // I/O cycles never touch column, transfer or write strobes - see R9
      phasePins.colStrobe_n = !(act && mid && !io);
      phasePins.transferOutEn_n = !(rdLike && mid && !io);
      phasePins.writeEnable_n = !(c == CY_WRITE && mid && !io);
      // Read data reaches the host latches only at Q4 - see R4
      phasePins.dataLatchStrobe = rdLike && q == Q4;
      // Register data flows outward on an I/O read - see R10
      phasePins.dirOutEn_n = !(rdLike && io && q != Q1);
      // Inbound direction held for the whole write cycle - see R14
      phasePins.dirInEn_n = !(c == CY_WRITE);
      // Device drives the address in Q1, register data after it
      phasePins.ladOutEn_n = !(act && (q == Q1 || (rdLike && io)));
      phasePins.ioReadStrobe = rdLike && io && q == Q1;
      phasePins.ioWriteStrobe = (c == CY_WRITE) && io && q == Q3;
   endfunction

   // Idle pin levels under reset
   localparam hap_pins_t PINS_IDLE = '{
      dataLatchStrobe: 1'b0, dirOutEn_n: 1'b1, dirInEn_n: 1'b1,
      latchOutEn_n: 1'b1, addrLatch_n: 1'b1, transferOutEn_n: 1'b1,
      colStrobe_n: 1'b1, writeEnable_n: 1'b1, ladOutEn_n: 1'b1,
      ioReadStrobe: 1'b0, ioWriteStrobe: 1'b0};

   // Address travels with the strobes; it must be steady while select
   // is low, so a skewed capture cannot mix two addresses
   assign syncIn = {host_select_n, host_read_strobe_n,
                    host_write_strobe_n, hostAddr};

   // Host pins pass two flops before any decode
   hap_sync #(
      .W(`HAP_SYNC_W),
      .INIT({3'h7, {`HAP_ADDR_W{1'b0}}})
   ) u_sync (
      .clock(clock),
      .rstn(rstn),
      .din(syncIn),
      .dout(syncOut)
   );

   assign {csS_n, rdS_n, wrS_n, addrS} = syncOut;
   assign reqActive = !csS_n && (!rdS_n || !wrS_n);
   assign reqWrite = !wrS_n;
   assign csFall = s.csPrev_n && !csS_n;
   assign curAddr = csFall ? addrS : s.hostAddr;

   // Next-state logic for the whole port
   always_comb begin
      logic hitOk;
      logic [`HAP_ADDR_W-1:0] pAddr;
      hitOk = 1'b0;
      pAddr = '0;
      next_s = s;
      next_s.reqPrev = reqActive;
      next_s.csPrev_n = csS_n;
      // Quarters rotate every clock
      case (s.quarter)
         Q1: next_s.quarter = Q2;
         Q2: next_s.quarter = Q3;
         Q3: next_s.quarter = Q4;
         Q4: next_s.quarter = Q1;
         default: next_s.quarter = Q1;
      endcase
      // Address taken on the falling edge of select
      if (csFall) begin
         next_s.hostAddr = addrS;
      end
      // Ready only stands while the host keeps its request - see R17
      next_s.ready = s.ready && reqActive;
      // Host release arms a prefetch in block or rmw mode
      if (s.reqPrev && !reqActive) begin
         next_s.served = 1'b0;
         if (s.served && !s.servedWrite && accessMode == MODE_BLOCK) begin
            next_s.prefPending = 1'b1; // see R5, R6
            next_s.prefValid = 1'b0;
            next_s.prefAddr = s.lastAddr + `HAP_ADDR_STEP;
         end else if (s.served && s.servedWrite &&
                      accessMode == MODE_RMW) begin
            next_s.prefPending = 1'b1; // see R8
            next_s.prefValid = 1'b0;
            next_s.prefAddr = s.lastAddr;
         end
      end
      // Prefetched word already latched: answer on select fall
      if (csFall && !rdS_n && wrS_n && !s.served && s.prefValid &&
          accessMode == MODE_BLOCK && addrS == s.prefAddr) begin
         next_s.ready = 1'b1; // see R7
         next_s.served = 1'b1;
         next_s.servedWrite = 1'b0;
         next_s.lastAddr = addrS;
      end
      // Read ready appears at the start of Q2 - see R4
      if (s.quarter == Q1 && s.cycle == CY_READ) begin
         next_s.ready = 1'b1;
      end
      // Machine cycle boundary: requests other than prefetch hits on select fall are taken here. A request
      // that missed setup is simply seen at the following Q4 - see R2
      if (s.quarter == Q4) begin
         next_s.cycle = CY_IDLE;
         if (s.cycle == CY_PREF) begin
            next_s.prefValid = 1'b1;
         end
         // A prefetch finishing now also counts as a hit
         hitOk = (s.prefValid || s.cycle == CY_PREF) &&
                 accessMode == MODE_BLOCK && curAddr == s.prefAddr;
         if (reqActive && !s.served && !csFall) begin
            next_s.served = 1'b1;
            next_s.lastAddr = curAddr;
            next_s.servedWrite = reqWrite;
            if (reqWrite) begin
               // Any running cycle ends at this Q4, so the buffer is
               // free and ready rises now - see R12, R13
               next_s.cycle = CY_WRITE; // see R1
               next_s.ready = 1'b1;
               next_s.prefValid = 1'b0;
               next_s.prefPending = 1'b0;
            end else if (hitOk && !isIo(curAddr)) begin
               next_s.ready = 1'b1; // see R7
            end else begin
               next_s.cycle = CY_READ; // see R1
            end
            next_s.cycAddr = curAddr;
            next_s.cycIo = isIo(curAddr); // see R11
         end else if (next_s.prefPending) begin
            // Host demand goes first; prefetch uses an idle cycle
            pAddr = next_s.prefAddr;
            next_s.cycle = CY_PREF;
            next_s.prefPending = 1'b0;
            next_s.cycAddr = pAddr;
            next_s.cycIo = isIo(pAddr);
         end
      end
      // Pins follow the cycle and quarter about to start
      next_s.pins = phasePins(next_s.cycle, next_s.cycIo, next_s.quarter);
      // Address in Q1, register data on an I/O read
      if (next_s.quarter == Q1) begin
         next_s.ladOut = {`HAP_LAD_PAD, next_s.cycAddr};
      end else begin
         next_s.ladOut = ioReadData;
      end
      // I/O write data is taken from the inbound buffers
      if (next_s.pins.ioWriteStrobe) begin
         next_s.ioWriteData = local_addr_data_bus_in;
      end
   end

   // State register; every field idle under reset
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s.quarter <= Q1;
         s.cycle <= CY_IDLE;
         s.cycIo <= 1'b0;
         s.cycAddr <= '0;
         s.hostAddr <= '0;
         s.lastAddr <= '0;
         s.prefAddr <= '0;
         s.prefValid <= 1'b0;
         s.prefPending <= 1'b0;
         s.served <= 1'b0;
         s.servedWrite <= 1'b0;
         s.reqPrev <= 1'b0;
         s.csPrev_n <= 1'b1;
         s.ready <= 1'b0;
         s.pins <= PINS_IDLE;
         s.ladOut <= '0;
         s.ioWriteData <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign host_ready = s.ready;
   assign host_data_latch_strobe = s.pins.dataLatchStrobe;
   assign host_latch_out_en_n = s.pins.latchOutEn_n;
   assign buffer_dir_out_en_n = s.pins.dirOutEn_n;
   assign buffer_dir_in_en_n = s.pins.dirInEn_n;
   assign addr_latch_strobe_n = s.pins.addrLatch_n;
   assign transfer_out_en_n = s.pins.transferOutEn_n;
   assign colStrobe_n = s.pins.colStrobe_n;
   assign writeEnable_n = s.pins.writeEnable_n;
   assign local_addr_data_bus_out = s.ladOut;
   assign local_addr_data_bus_oe_n = s.pins.ladOutEn_n;
   assign ioReadStrobe = s.pins.ioReadStrobe;
   assign ioWriteStrobe = s.pins.ioWriteStrobe;
   assign ioIndex = s.cycAddr[`HAP_IO_IDX_HI:`HAP_IO_IDX_LO];
   assign ioWriteData = s.ioWriteData;

endmodule

// ### hap_port_asserts.sv
// Timing checks on the host port, seen from its pins only
module hap_port_checker (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Host request pins
   input wire logic host_select_n,
   input wire logic host_read_strobe_n,
   input wire logic host_write_strobe_n,
   // Port outputs
   input wire logic host_ready,
   input wire logic host_data_latch_strobe,
   input wire logic host_latch_out_en_n,
   input wire logic buffer_dir_out_en_n,
   input wire logic buffer_dir_in_en_n,
   input wire logic addr_latch_strobe_n,
   input wire logic transfer_out_en_n,
   input wire logic colStrobe_n,
   input wire logic writeEnable_n,
   input wire logic ioReadStrobe,
   input wire logic ioWriteStrobe
);
   timeunit 1ns;
   timeprecision 1ps;
   // One clock domain, so one default for every check
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   a_write_ready: assert property (
      $fell(buffer_dir_in_en_n) |-> host_ready)
      else $error("write cycle began without ready");
   a_latch_at_q4: assert property (
      host_data_latch_strobe |-> $rose(addr_latch_strobe_n)
      && buffer_dir_in_en_n)
      else $error("latch strobe outside read Q4");
   a_strobe_pulse: assert property (
      host_data_latch_strobe |=> !host_data_latch_strobe)
      else $error("latch strobe longer than one clock");
   // Memory must stay quiet while the buffers face the host
   a_io_read_path: assert property (
      ioReadStrobe |=> (!buffer_dir_out_en_n && colStrobe_n
      && transfer_out_en_n) [*3])
      else $error("register read path wrong");
   a_write_dir_in: assert property (
      $fell(buffer_dir_in_en_n) |-> !buffer_dir_in_en_n [*4])
      else $error("inbound direction dropped early");
   a_write_end_q4: assert property (
      $fell(writeEnable_n) |-> !host_latch_out_en_n ##1 !colStrobe_n
      ##1 (addr_latch_strobe_n && colStrobe_n && host_latch_out_en_n))
      else $error("write cycle did not end at Q4");
   a_ready_release: assert property (
      $fell(host_ready) |-> host_select_n
      || (host_read_strobe_n && host_write_strobe_n))
      else $error("ready fell with request held");
   a_ready_cause: assert property (
      $rose(host_ready) |-> !host_select_n)
      else $error("ready rose without a request");
   a_io_write_in: assert property (
      ioWriteStrobe |-> !buffer_dir_in_en_n)
      else $error("register write without inbound path");
endmodule

bind hap_port hap_port_checker i_chk (.clock(clock), .rstn(rstn),
   .host_select_n(host_select_n), .host_ready(host_ready),
   .host_read_strobe_n(host_read_strobe_n),
   .host_write_strobe_n(host_write_strobe_n),
   .host_data_latch_strobe(host_data_latch_strobe),
   .host_latch_out_en_n(host_latch_out_en_n),
   .buffer_dir_out_en_n(buffer_dir_out_en_n),
   .buffer_dir_in_en_n(buffer_dir_in_en_n),
   .addr_latch_strobe_n(addr_latch_strobe_n),
   .transfer_out_en_n(transfer_out_en_n), .colStrobe_n(colStrobe_n),
   .writeEnable_n(writeEnable_n), .ioReadStrobe(ioReadStrobe),
   .ioWriteStrobe(ioWriteStrobe));

// ### hap_host_model.sv
`include "hap_defines.svh"

// Host processor with its external address and data latches
module hap_host_model (
   // Clock
   input wire logic clock,
   // Request pins
   output logic host_select_n,
   output logic host_read_strobe_n,
   output logic host_write_strobe_n,
   output logic [`HAP_ADDR_W-1:0] hostAddr,
   // Handshake, latch strobe and local bus level
   input wire logic host_ready,
   input wire logic host_data_latch_strobe,
   input wire logic [`HAP_LAD_W-1:0] ladWire
);
   timeunit 1ns;
   timeprecision 1ps;

   // Word held by the external read latch
   logic [`HAP_LAD_W-1:0] latched = '0;

   // Idle pins at time zero
   initial begin
      host_select_n = 1'h1;
      host_read_strobe_n = 1'h1;
      host_write_strobe_n = 1'h1;
      hostAddr = '0;
   end

   // Read latch loads only on the port's strobe
   always @(posedge clock)
      if (host_data_latch_strobe)
         latched <= ladWire;

   // One access; entered just after a rising edge, returns on one
   task automatic access(input logic wr,
         input logic [`HAP_ADDR_W-1:0] a, output int lat);
      lat = 0;
      hostAddr <= a;
      host_select_n <= 1'h0;
      host_read_strobe_n <= wr;
      host_write_strobe_n <= ~wr;
      // Hold the request until ready is seen, within a bound
      do begin
         @(negedge clock);
         lat++;
      end while (host_ready !== 1'h1 && lat < 40);
      // Release at the next edge; new write data only after ready
      @(posedge clock);
      host_select_n <= 1'h1;
      host_read_strobe_n <= 1'h1;
      host_write_strobe_n <= 1'h1;
      // Released address lines do not keep the old value
      hostAddr <= ~a;
      for (int i = 0; i < 8 && host_ready !== 1'h0; i++)
         @(negedge clock);
      if (host_ready !== 1'h0)
         lat = 99;
      @(posedge clock);
   endtask
endmodule

// ### tb.sv
`include "hap_defines.svh"

// Count a comparison and report a mismatch at once
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
   errTotal++; \
   $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); end end

module tb
   import hap_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // Clock, reset, host pins and port outputs
   logic clock = 1'h0;
   logic rstn = 1'h0;
   logic sel_n, rd_n, wr_n, rdy, dStb, hoe_n, dOut_n, dIn_n;
   logic alt_n, trOe_n, col_n, we_n, ladOe_n, ioRd, ioWr;
   logic [`HAP_ADDR_W-1:0] hAddr;
   logic [`HAP_IO_IDX_HI:0] ioIdx;
   logic [`HAP_LAD_W-1:0] ladOut, ioWrData, ioData, memWord, ladIn;
   logic [`HAP_LAD_W-1:0] lastRd = '0;
   logic colLow = 1'h0;
   hap_mode_t mode;
   // Counters; minLat is the shortest read-miss wait seen
   int errTotal = 0;
   int checked = 0;
   int cyc = 0;
   int minLat = 0;

   always #5 clock = ~clock;
   always @(posedge clock)
      cyc <= cyc + 1;
   // Memory strobe seen at all, and address of the last memory read cycle
   always @(posedge clock) begin
      if (col_n === 1'h0)
         colLow <= 1'h1;
      if (alt_n === 1'h0 && dIn_n === 1'h1 && ladOe_n === 1'h0)
         lastRd <= ladOut;
   end
   // Bus wire: the port while it drives, else the far side
   assign ladIn = ladOe_n ? memWord : ladOut;

   hap_port i_dut (.clock(clock), .rstn(rstn), .host_select_n(sel_n),
      .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n),
      .hostAddr(hAddr), .host_ready(rdy), .host_data_latch_strobe(dStb),
      .host_latch_out_en_n(hoe_n), .buffer_dir_out_en_n(dOut_n),
      .buffer_dir_in_en_n(dIn_n), .addr_latch_strobe_n(alt_n),
      .transfer_out_en_n(trOe_n), .colStrobe_n(col_n),
      .writeEnable_n(we_n), .local_addr_data_bus_in(ladIn),
      .local_addr_data_bus_out(ladOut), .local_addr_data_bus_oe_n(ladOe_n),
      .accessMode(mode), .ioReadData(ioData), .ioReadStrobe(ioRd),
      .ioWriteStrobe(ioWr), .ioIndex(ioIdx), .ioWriteData(ioWrData));
   hap_host_model i_host (.clock(clock), .host_select_n(sel_n),
      .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n),
      .hostAddr(hAddr), .host_ready(rdy), .host_data_latch_strobe(dStb),
      .ladWire(ladIn));

   // Counts, verdict and end of run
   task automatic summarize();
      $display("checked %0d mismatches %0d", checked, errTotal);
      if (errTotal == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // One host access; a hang ends the run
   task automatic run(input logic wr, input logic [`HAP_ADDR_W-1:0] a,
         output int lat);
      i_host.access(wr, a, lat);
      if (lat >= 40) begin
         errTotal++;
         summarize();
      end
   endtask

   // Read misses started in each of the four quarters
   task automatic t_phase();
      int lat, s, r0, mx, sum;
      s = cyc;
      run(1'h0, 27'h0000040, lat);
      r0 = s + lat;
      minLat = 99;
      mx = 0;
      sum = 0;
      for (int k = 0; k < 4; k++) begin
         for (int j = 0; j < 4 && (cyc - r0) % 4 != k; j++)
            @(posedge clock);
         s = cyc;
         run(1'h0, 27'h0000050 + 27'(k), lat);
         `CHK((s + lat - r0) % 4, 0)
         sum += lat;
         minLat = lat < minLat ? lat : minLat;
         mx = lat > mx ? lat : mx;
      end
      // The four start quarters spread the wait over exactly three clocks
      `CHK(mx - minLat, 3)
      `CHK(sum, 4 * minLat + 6)
      $display("phase test done");
   endtask

   // Block mode: every read release prefetches the next word
   task automatic t_block();
      int lat;
      mode <= MODE_BLOCK;
      run(1'h0, 27'h0000100, lat);
      for (int i = 1; i < 3; i++) begin
         repeat (12) @(posedge clock);
         run(1'h0, 27'h0000100 + 27'(i), lat);
         `CHK(lat, minLat - 2)
      end
      repeat (12) @(posedge clock);
      run(1'h0, 27'h0000180, lat);
      `CHK(lat >= minLat, 1'h1)
      $display("block test done");
   endtask

   // Register reads in every mode, memory strobes held off
   task automatic t_io();
      int lat;
      for (int m = 0; m < 3; m++) begin
         mode <= hap_mode_t'(m);
         ioData <= 32'hC0DE0000 + 32'(m);
         repeat (12) @(posedge clock);
         colLow <= 1'h0;
         run(1'h0, {`HAP_IO_TAG, 6'h10}, lat);
         `CHK(i_host.latched, ioData)
         `CHK(colLow, 1'h0)
      end
      $display("register read test done");
   endtask

   // Back-to-back writes, a register write, then read-modify-write
   task automatic t_write();
      int lat, s, r1;
      mode <= MODE_RANDOM;
      repeat (12) @(posedge clock);
      s = cyc;
      run(1'h1, 27'h0000300, lat);
      r1 = s + lat;
      `CHK(lat >= minLat - 1 && lat <= minLat + 2, 1'h1)
      s = cyc;
      run(1'h1, 27'h0000301, lat);
      `CHK((s + lat - r1) % 4, 0)
      memWord <= 32'h5A5A1234;
      run(1'h1, {`HAP_IO_TAG, 6'h21}, lat);
      `CHK(ioWrData, 32'h5A5A1234)
      `CHK(ioIdx, 6'h21)
      mode <= MODE_RMW;
      run(1'h1, 27'h0000400, lat);
      repeat (16) @(posedge clock);
      `CHK(lastRd, {`HAP_LAD_PAD, 27'h0000400})
      $display("write test done");
   endtask

   // Main sequence
   initial begin
      mode = MODE_RANDOM;
      ioData = 32'h0;
      memWord = 32'h0;
      repeat (10) @(posedge clock);
      rstn <= 1'h1;
      repeat (2) @(posedge clock);
      t_phase();
      t_block();
      t_io();
      t_write();
      summarize();
   end
endmodule
